// ---- include/dpc_pkg.sv ----
// Shared types and constants for the two-port memory port controller.
// Assumes one 250 MHz clock and an asynchronous memory on the far side.
package dpc_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 17'h1FFFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 17'h1FFFF;
  localparam int TOKEN_COUNT = 8;
  // Time in ns for select/address to settle before a write strobe
  localparam int SETTLE_NS = 12;
  localparam int CLK_NS    = 4;
  localparam logic [3:0] SETTLE_CYC =
    4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // Time the strobe is held low, and read access time
  localparam int STROBE_NS = 12;
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    DPC_OP_READ,
    DPC_OP_WRITE,
    DPC_OP_TOKEN_CLAIM,
    DPC_OP_TOKEN_RELEASE
  } dpc_op_t;

  typedef enum {
    DPC_IDLE,
    DPC_SETUP,
    DPC_STROBE,
    DPC_CHECK
  } dpc_state_t;

  // Pins toward one memory port
  typedef struct packed {
    logic              sel_n;
    logic              token_space_select_n;
    logic              rw_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_en;
  } dpc_pins_t;

  // A request from the user side
  typedef struct packed {
    dpc_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpc_req_t;

  // Complete state of the controller
  typedef struct packed {
    dpc_state_t        st;
    logic [3:0]        cnt;
    dpc_req_t          req;
    dpc_pins_t         pins;
    logic              ready;
    logic              done;
    logic              retry;
    logic              granted;
    logic [DATA_W-1:0] rdata;
    logic              irq;
  } dpc_state_reg_t;
endpackage

// ---- testbench/dpc_mem_model.sv ----
// Behavioural model of one port of the shared memory, the left side.
// Assumes the bench plays the peer port through the peer_ inputs.
module dpc_mem_model
  import dpc_pkg::*;
(
  input  wire dpc_pins_t              pins_in,       // Pins from controller
  input  wire logic                   peer_mbox_in,  // Peer writes 1FFFE
  input  wire logic [TOKEN_COUNT-1:0] peer_own_in,   // Tokens peer holds
  input  wire logic                   arb_busy_n_in, // Arbiter says lost
  output logic [DATA_W-1:0]           data_out,      // Data bus
  output logic                        busy_n_out,    // Busy, low
  output logic                        irq_n_out,     // Mailbox irq, low
  output logic                        peer_irq_n_out // Peer's irq, low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0]      mem [0:(1<<ADDR_W)-1];
  logic [TOKEN_COUNT-1:0] own_q = '0;
  logic [DATA_W-1:0]      last = '0;
  logic [DATA_W-1:0]      drv;
  logic                   sel;
  logic                   tsel;
  logic [2:0]             tok;
  ////////////////////////////////////////
  // Standby unless one of the two selects is low
  assign sel  = !pins_in.sel_n;
  assign tsel = !pins_in.token_space_select_n;
  assign tok  = pins_in.addr[2:0];
  // One busy line seen here, so both low together cannot occur
  // Busy ignores read or write; it only follows the arbiter
  assign busy_n_out = arb_busy_n_in;
  initial irq_n_out = 1'b1;
  initial peer_irq_n_out = 1'b1;
  // Level-sensitive writes; a losing port's memory write is dropped, token writes are not
  always @* begin
    if (sel && !pins_in.rw_n && busy_n_out) begin
      mem[pins_in.addr] = pins_in.dout;
      if (pins_in.addr == MBOX_RIGHT_ADDR)
        peer_irq_n_out = 1'b0;
    end
    if (tsel && !pins_in.rw_n)
      own_q[tok] = !pins_in.dout[0] && !peer_own_in[tok];
    if (peer_mbox_in)
      irq_n_out = 1'b0;
    else if (sel && !pins_in.oe_n && pins_in.addr == MBOX_LEFT_ADDR)
      irq_n_out = 1'b1;
  end
  // Value driven while selected; token bit spread on every line
  assign drv = tsel ? {DATA_W{!own_q[tok]}} : mem[pins_in.addr];
  // Track the driven value so a release never races the capture
  always @* if (!pins_in.oe_n && (sel || tsel)) last = drv;
  // Released bus shows the inverse of the last value, never a stale copy
  assign data_out = (pins_in.oe_n || !(sel || tsel)) ? ~last : drv;
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for one left-port controller and a memory model.
// Assumes the controller's contract of one request at a time.
module tb_top
  import dpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock_in;
  logic                   sys_rst_in;
  logic                   req_valid;
  dpc_req_t               req;
  logic                   ready, done, retry, granted, irq;
  logic [DATA_W-1:0]      rdata, data, d;
  dpc_pins_t              pins;
  logic                   busy_n, mbox_n, peer_mbox, arb_n, retry_seen;
  logic                   peer_irq_n;
  logic [TOKEN_COUNT-1:0] peer_own;
  logic [ADDR_W-1:0]      a;
  int                     num_errors = 0, n_checks = 0, k;
  int                     seed = 32'h8EB01A8F;
  dpc_port_ctrl #(.IS_LEFT(1'b1)) i_dpc_port_ctrl (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .req_valid_in(req_valid), .req_in(req),
    .req_ready_out(ready), .done_out(done), .retry_out(retry),
    .granted_out(granted), .rdata_out(rdata), .mbox_irq_out(irq),
    .pins_out(pins), .data_pin_in(data), .busy_n_in(busy_n),
    .mailbox_irq_n_in(mbox_n));
  dpc_mem_model i_dpc_mem_model (.pins_in(pins), .peer_mbox_in(peer_mbox),
    .peer_own_in(peer_own), .arb_busy_n_in(arb_n), .data_out(data),
    .busy_n_out(busy_n), .irq_n_out(mbox_n),
    .peer_irq_n_out(peer_irq_n));
  ////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [DATA_W-1:0] s, e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Edges from the sampling negedge after taking to the done pulse
  function automatic int exp_cycles(input dpc_op_t op, input logic lost);
    if (op == DPC_OP_WRITE && lost) return int'(SETTLE_CYC);
    if (op == DPC_OP_TOKEN_CLAIM)
      return int'(SETTLE_CYC) + 2 * int'(STROBE_CYC);
    return int'(SETTLE_CYC) + int'(STROBE_CYC);
  endfunction
  // One request, then a bounded wait for its completion pulse
  task automatic do_op(input dpc_op_t op, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] wd);
    int i;
    @(negedge clock_in);
    req_valid = 1'b1;
    req = {op, ad, wd};
    @(negedge clock_in);
    req_valid = 1'b0;
    chk("ready_busy", ready, 1'b0);
    for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clock_in);
    if (i == 20) begin
      num_errors++;
      test_done();
    end else begin
      retry_seen = retry;
      chk("cycles", i, exp_cycles(op, !arb_n));
      chk("ready_idle", ready, 1'b1);
      chk("standby", {pins.sel_n, pins.token_space_select_n}, 2'h3);
    end
  endtask
  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 10 && irq !== v; i++) @(negedge clock_in);
    chk("mbox_irq", irq, v);
  endtask
  function automatic logic exp_grant(input int t);
    return !peer_own[t];
  endfunction
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clock_in);
    num_errors++;
    test_done();
  end
  ////////////////////////////////////////
  initial begin
    sys_rst_in = 1'b1;
    req_valid = 1'b0;
    req = '0;
    peer_mbox = 1'b0;
    peer_own = 8'h04;
    arb_n = 1'b1;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk("idle_sel", {pins.sel_n, pins.token_space_select_n}, 2'h3);
    // Random words, both mailbox words first
    for (k = 0; k < 6; k++) begin
      a = k == 0 ? MBOX_LEFT_ADDR : k == 1 ? MBOX_RIGHT_ADDR
                 : ADDR_W'($random(seed));
      d = DATA_W'({$random(seed), $random(seed)});
      do_op(DPC_OP_WRITE, a, d);
      if (k == 1) chk("peer_irq", peer_irq_n, 1'b0);
      do_op(DPC_OP_READ, a, '0);
      chk("rdata", rdata, d);
    end
    // Peer writes our mailbox, our read clears it
    @(negedge clock_in) peer_mbox = 1'b1;
    @(negedge clock_in) peer_mbox = 1'b0;
    wait_irq(1'b1);
    do_op(DPC_OP_READ, MBOX_LEFT_ADDR, '0);
    wait_irq(1'b0);
    // Losing arbitration: write withheld, word kept
    arb_n = 1'b0;
    do_op(DPC_OP_WRITE, a, ~d);
    chk("retry", retry_seen, 1'b1);
    arb_n = 1'b1;
    do_op(DPC_OP_READ, a, '0);
    chk("kept", rdata, d);
    do_op(DPC_OP_WRITE, a, ~d);
    chk("retry_free", retry_seen, 1'b0);
    do_op(DPC_OP_READ, a, '0);
    chk("landed", rdata, ~d);
    // Every token, random high address bits; peer holds one
    for (k = 0; k < TOKEN_COUNT; k++) begin
      a = ADDR_W'($random(seed));
      a[2:0] = k[2:0];
      do_op(DPC_OP_TOKEN_CLAIM, a, '0);
      chk("granted", granted, exp_grant(k));
      do_op(DPC_OP_TOKEN_RELEASE, a, '1);
    end
    test_done();
  end
endmodule

// ---- verilog/dpc_port_ctrl.sv ----
// Controller for one port of a two-port asynchronous shared memory.
// Assumes a master-mode memory whose busy line is push-pull toward us.
//
// Notes on behaviour
// - Right port clears its interrupt by reading 1FFFF.
// - Interrupt outputs may be ignored; mailboxes act as plain memory.
// - A width-expanded array uses exactly one master.
// - Hold address and select until busy settles before strobing.
// - Depth-cascaded busy lines combine through an external AND.
// - Claim a token by writing zero, release by writing one.
module dpc_port_ctrl
  import dpc_pkg::*;
#(
  parameter bit IS_LEFT = 1'b1
) (
  input  wire logic              clock_in,        // 250 MHz clock
  input  wire logic              sys_rst_in,      // Async reset, high
  input  wire logic              req_valid_in,    // Start a request
  input  wire dpc_req_t          req_in,          // Operation and operands
  output logic                   req_ready_out,   // Idle, may take request
  output logic                   done_out,        // Pulse at completion
  output logic                   retry_out,       // Pulse: write hit busy
  output logic                   granted_out,     // Token claim succeeded
  output logic [DATA_W-1:0]      rdata_out,       // Read data
  output logic                   mbox_irq_out,    // Mailbox interrupt, high
  output dpc_pins_t              pins_out,        // Pins to the memory
  input  wire logic [DATA_W-1:0] data_pin_in,     // Data bus from memory
  input  wire logic              busy_n_in,       // Busy from master, low
  input  wire logic              mailbox_irq_n_in // This port's interrupt
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  logic [DATA_W+1:0] sync1_q;
  logic [DATA_W+1:0] sync2_q;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= {DATA_W+2{1'b1}};
      sync2_q <= {DATA_W+2{1'b1}};
    end else begin
      sync1_q <= {busy_n_in, mailbox_irq_n_in, data_pin_in};
      sync2_q <= sync1_q;
    end
  end
  logic              busy_s;
  logic              irq_s;
  logic [DATA_W-1:0] data_s;
  // Busy comes from the single master, or the AND of depth-cascaded parts
  assign busy_s = ~sync2_q[DATA_W+1];
  assign irq_s  = ~sync2_q[DATA_W];
  assign data_s = sync2_q[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Own mailbox address: the one whose read clears our interrupt
  logic [ADDR_W-1:0] own_mbox;
  assign own_mbox = IS_LEFT ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;

  dpc_state_reg_t s_q;
  dpc_state_reg_t s_d;
  logic           is_write;
  logic           is_token;

  // Next state; idle pins keep both selects high for standby
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.retry = 1'b0;
    s_d.irq   = irq_s;
    is_token  = (s_q.req.op == DPC_OP_TOKEN_CLAIM) ||
                (s_q.req.op == DPC_OP_TOKEN_RELEASE);
    is_write  = (s_q.req.op != DPC_OP_READ);
    case (s_q.st)
      DPC_IDLE: begin
        s_d.pins.sel_n                = 1'b1;
        s_d.pins.token_space_select_n = 1'b1;
        s_d.pins.rw_n                 = 1'b1;
        s_d.pins.oe_n                 = 1'b1;
        s_d.pins.dout_en              = 1'b0;
        if (req_valid_in) begin
          s_d.req = req_in;
          s_d.st  = DPC_SETUP;
          s_d.cnt = SETTLE_CYC;
          s_d.pins.addr = req_in.addr;
          if ((req_in.op == DPC_OP_TOKEN_CLAIM) ||
              (req_in.op == DPC_OP_TOKEN_RELEASE)) begin
            // Only the three low lines matter in token space
            s_d.pins.addr = {{(ADDR_W-3){1'b0}}, req_in.addr[2:0]};
            s_d.pins.token_space_select_n = 1'b0;
            // Zero claims, one releases, on every data bit
            s_d.pins.dout = (req_in.op == DPC_OP_TOKEN_CLAIM) ?
                            {DATA_W{1'b0}} : {DATA_W{1'b1}};
          end else begin
            s_d.pins.sel_n = 1'b0;
            s_d.pins.dout  = req_in.wdata;
          end
        end
      end
      // Address and select settle so the master's busy is valid
      DPC_SETUP: begin
        if (s_q.cnt > 4'h1) begin
          s_d.cnt = s_q.cnt - 4'h1;
        end else if (is_write && !is_token && busy_s) begin
          // Writing now would be inhibited; give it back to the user
          s_d.st    = DPC_IDLE;
          s_d.retry = 1'b1;
          s_d.done  = 1'b1;
          s_d.pins.sel_n = 1'b1;
        end else begin
          s_d.st  = DPC_STROBE;
          s_d.cnt = STROBE_CYC;
          s_d.pins.rw_n    = ~is_write;
          s_d.pins.oe_n    = is_write;
          s_d.pins.dout_en = is_write;
        end
      end
      DPC_STROBE: begin
        if (s_q.cnt > 4'h1) begin
          s_d.cnt = s_q.cnt - 4'h1;
        end else begin
          s_d.pins.rw_n    = 1'b1;
          s_d.pins.dout_en = 1'b0;
          s_d.rdata        = data_s;
          if (s_q.req.op == DPC_OP_TOKEN_CLAIM) begin
            // Read back to learn whether the claim won the token
            s_d.st  = DPC_CHECK;
            s_d.cnt = STROBE_CYC;
            s_d.pins.oe_n = 1'b0;
          end else begin
            s_d.st   = DPC_IDLE;
            s_d.done = 1'b1;
            s_d.pins.oe_n  = 1'b1;
            s_d.pins.sel_n = 1'b1;
            s_d.pins.token_space_select_n = 1'b1;
          end
        end
      end
      // Token read: replicated bit, zero means this side owns it
      DPC_CHECK: begin
        if (s_q.cnt > 4'h1) begin
          s_d.cnt = s_q.cnt - 4'h1;
        end else begin
          s_d.granted = ~data_s[0];
          s_d.rdata   = data_s;
          s_d.st      = DPC_IDLE;
          s_d.done    = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.pins.token_space_select_n = 1'b1;
        end
      end
      default: begin
        s_d.st = DPC_IDLE;
      end
    endcase
    // Ready is registered so the output comes straight from a flop
    s_d.ready = (s_d.st == DPC_IDLE);
  end

  // State register
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= '{st: DPC_IDLE, cnt: CNT_ZERO, req: '0,
               pins: '{sel_n: 1'b1, token_space_select_n: 1'b1,
                       rw_n: 1'b1, oe_n: 1'b1, addr: '0, dout: '0,
                       dout_en: 1'b0},
               ready: 1'b1, done: 1'b0, retry: 1'b0, granted: 1'b0,
               rdata: '0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign req_ready_out = s_q.ready;
  assign done_out      = s_q.done;
  assign retry_out     = s_q.retry;
  assign granted_out   = s_q.granted;
  assign rdata_out     = s_q.rdata;
  assign mbox_irq_out  = s_q.irq;
  assign pins_out      = s_q.pins;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_standby_idle: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (s_q.st == DPC_IDLE) |->
      (s_q.pins.sel_n && s_q.pins.token_space_select_n))
    else $error("selects active while idle");
  // Token writes ignore busy, so only memory strobes need it settled
  a_strobe_after_settle: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    $fell(s_q.pins.rw_n) |-> ($past(s_q.st) == DPC_SETUP) &&
      (!$past(busy_s) || !$past(s_q.pins.token_space_select_n)))
    else $error("write strobe without settled busy");
  a_busy_write_gate: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (s_q.st == DPC_SETUP && s_q.cnt == 4'h1 && busy_s && is_write
     && !is_token) |=> retry_out && s_q.pins.rw_n)
    else $error("write issued into busy");
  a_token_low_addr: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    !s_q.pins.token_space_select_n |-> s_q.pins.addr[ADDR_W-1:3] == '0)
    else $error("token access uses high address");
  a_claim_data_zero: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (!s_q.pins.rw_n && s_q.req.op == DPC_OP_TOKEN_CLAIM)
      |-> (s_q.pins.dout == '0) && s_q.pins.dout_en)
    else $error("claim not writing zero");
  a_release_data_one: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (!s_q.pins.rw_n && s_q.req.op == DPC_OP_TOKEN_RELEASE)
      |-> s_q.pins.dout[0])
    else $error("release not writing one");
  a_irq_follow: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (sync2_q[DATA_W] == 1'b0) |=> mbox_irq_out)
    else $error("mailbox interrupt not reported");
  a_mem_select: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (!s_q.pins.sel_n) |-> s_q.pins.token_space_select_n)
    else $error("both selects active at once");
  // A read of our own mailbox must hold select and output enable low
  a_mbox_read_clear: assert property (@(posedge clock_in)
    disable iff (sys_rst_in)
    (s_q.st == DPC_STROBE && s_q.req.op == DPC_OP_READ &&
     s_q.req.addr == own_mbox) |-> (!s_q.pins.sel_n && !s_q.pins.oe_n))
    else $error("mailbox read does not clear interrupt");
endmodule
